/* hw/serial_io_port.v */
// Serially addressed 8-bit I/O port, device side, behind its SPI pins.
// Assumes all serial and port pins are asynchronous to clock_i and that
// the serial clock is far slower than clock_i (several cycles per level).
`include "serial_io_port_map.vh"

module serial_io_port (
    input wire clock_i,             // 125 MHz system clock
    input wire rst_n_i,             // Synchronous reset, active low
    input wire sck_i,               // Serial clock pin
    input wire cs_n_i,              // Chip enable pin, active low
    input wire mosi_i,              // Serial data in pin
    output wire miso_o,             // Serial data out level
    output wire miso_oe_o,          // Serial data out enable
    input wire ident_pin_0_i,       // Ident strap bit 0
    input wire ident_pin_1_i,       // Ident strap bit 1
    input wire [7:0] port_pins_i,   // Port pin levels
    output wire [7:0] port_pins_o,  // Port pin drive levels
    output wire [7:0] port_pins_oe_o, // Port pin enables, high drives
    output wire compare_flag_o,     // Live compare result
    input wire apply_hold_i,        // Stalls application of writes
    output wire drop_o              // A write was lost to a full queue
);

    // ============================================================
    // Local state codes
    localparam ST_IDLE = 2'h0;
    localparam ST_CTRL = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_DONE = 2'h3;

    // ============================================================
    // Registers
    reg [12:0] meta_q;
    reg [12:0] sync_q;
    reg sck_prev_q;
    reg cs_prev_q;
    reg [1:0] state_q;
    reg [2:0] bit_cnt_q;
    reg cpol_q;
    reg flag_snap_q;
    reg [7:0] shift_in_q;
    reg [7:0] shift_out_q;
    reg [7:0] ctrl_q;
    reg miso_q;
    reg miso_oe_q;
    reg push_valid_q;
    reg [15:0] push_data_q;
    reg drop_q;
    reg [7:0] data_q;
    reg [7:0] dir_q;
    reg [1:0] cmp_sel_q;
    reg cmp_flag_q;

    wire sck_s;
    wire cs_s;
    wire mosi_s;
    wire [1:0] ident_s;
    wire [7:0] pins_s;
    wire sck_edge;
    wire lead_edge;
    wire trail_edge;
    wire cs_fall;
    wire [7:0] byte_in;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire pop;
    wire [7:0] pop_ctrl;
    wire [7:0] pop_val;

    // ============================================================
    // Functions

    // Merge a data byte into a register by write mode
    function [7:0] apply_write;
        input [1:0] mode;
        input [7:0] old;
        input [7:0] val;
        begin
            case (mode)
                `WMODE_SET: apply_write = old | val;
                `WMODE_CLR: apply_write = old & ~val;
                default: apply_write = val;
            endcase
        end
    endfunction

    // Compare condition between data register and pins
    function cmp_eval;
        input [1:0] sel;
        input [7:0] dat;
        input [7:0] pins;
        begin
            case (sel)
                `CMP_EQUAL: cmp_eval = (dat == pins);
                `CMP_DIFFER: cmp_eval = (dat != pins);
                `CMP_ANY_HIGH: cmp_eval = ((dat & pins) != 8'h00);
                default: cmp_eval = ((dat & pins) == 8'h00);
            endcase
        end
    endfunction

    // Value returned for a read of either register
    function [7:0] read_value;
        input sel_dir;
        input [7:0] dir;
        input [7:0] dat;
        input [7:0] pins;
        begin
            if (sel_dir) begin
                read_value = dir;
            end else begin
                read_value = (dir & dat) | (~dir & pins);
            end
        end
    endfunction

    // ============================================================
    // Pin synchronisers: two flops before any logic looks
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_q <= `RST_SYNC;
            sync_q <= `RST_SYNC;
        end else begin
            meta_q <= {sck_i, cs_n_i, mosi_i, ident_pin_1_i, ident_pin_0_i, port_pins_i};
            sync_q <= meta_q;
        end
    end

    assign sck_s = sync_q[12];
    assign cs_s = sync_q[11];
    assign mosi_s = sync_q[10];
    assign ident_s = sync_q[9:8];
    assign pins_s = sync_q[7:0];

    // Previous levels for edge finding, read from second flop only
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_s;
        end
    end

    // leading edge leaves idle, trailing returns
    assign sck_edge = sck_s ^ sck_prev_q;
    assign lead_edge = sck_edge & (sck_s != cpol_q);
    assign trail_edge = sck_edge & (sck_s == cpol_q);
    assign cs_fall = cs_prev_q & ~cs_s;
    assign byte_in = {shift_in_q[6:0], mosi_s};

    // ============================================================
    // Serial transfer engine
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            cpol_q <= 1'b0;
            flag_snap_q <= 1'b0;
            shift_in_q <= 8'h00;
            shift_out_q <= 8'h00;
            ctrl_q <= 8'h00;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
            push_valid_q <= 1'b0;
            push_data_q <= 16'h0000;
            drop_q <= 1'b0;
        end else begin
            push_valid_q <= 1'b0;
            if (cs_s) begin
                state_q <= ST_IDLE;
                miso_oe_q <= 1'b0;
            end else if (cs_fall) begin
                cpol_q <= sck_s;
                flag_snap_q <= cmp_flag_q;
                bit_cnt_q <= 3'h0;
                state_q <= ST_CTRL;
                miso_oe_q <= 1'b0;
                drop_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_CTRL: begin
                        if (lead_edge) begin
                            // flag out once ident is known good
                            if (bit_cnt_q == `FLAG_BIT_IDX) begin
                                miso_q <= flag_snap_q;
                                miso_oe_q <= 1'b1;
                            end else begin
                                miso_q <= 1'b0;
                            end
                        end
                        if (trail_edge) begin
                            shift_in_q <= byte_in;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == `ID_LAST_IDX && byte_in[1:0] != ident_s) begin
                                // mismatch, stay quiet to the end
                                state_q <= ST_DONE;
                            end
                            if (bit_cnt_q == `BYTE_LAST_IDX) begin
                                ctrl_q <= byte_in;
                                shift_out_q <= read_value(byte_in[`CTL_DIR_BIT], dir_q, data_q,
                                    pins_s);
                                state_q <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (lead_edge) begin
                            miso_q <= shift_out_q[7];
                            shift_out_q <= {shift_out_q[6:0], 1'b0};
                        end
                        if (trail_edge) begin
                            shift_in_q <= byte_in;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == `BYTE_LAST_IDX) begin
                                state_q <= ST_DONE;
                                // Writes queue; a full queue loses this one
                                if (ctrl_q[`CTL_WRITE_BIT]) begin
                                    if (fifo_in_ready) begin
                                        push_valid_q <= 1'b1;
                                        push_data_q <= {ctrl_q, byte_in};
                                    end else begin
                                        drop_q <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    ST_DONE: begin
                        // Extra clocks past the data byte do nothing
                        state_q <= ST_DONE;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Write queue: decouples serial timing from register updates
    cmd_fifo #(
        .WIDTH(`CMDQ_WIDTH),
        .DEPTH(`CMDQ_DEPTH),
        .AW(`CMDQ_AW)
    ) u_cmd_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push_valid_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_data_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(~apply_hold_i),
        .out_data_o(fifo_out_data)
    );

    assign pop = fifo_out_valid & ~apply_hold_i;
    assign pop_ctrl = fifo_out_data[15:8];
    assign pop_val = fifo_out_data[7:0];

    // ============================================================
    // Register file; reads see queued writes only once applied
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            data_q <= `RST_DATA;
            dir_q <= `RST_DIR;
            cmp_sel_q <= `RST_CMP_SEL;
        end else if (pop) begin
            cmp_sel_q <= pop_ctrl[`CTL_CMP_HI:`CTL_CMP_LO];
            if (pop_ctrl[`CTL_DIR_BIT]) begin
                dir_q <= apply_write(pop_ctrl[`CTL_MODE_HI:`CTL_MODE_LO], dir_q, pop_val);
            end else begin
                // data byte loaded, or used as set or clear mask, by write mode
                data_q <= apply_write(pop_ctrl[`CTL_MODE_HI:`CTL_MODE_LO], data_q, pop_val);
            end
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            cmp_flag_q <= 1'b0;
        end else begin
            cmp_flag_q <= cmp_eval(cmp_sel_q, data_q, pins_s);
        end
    end

    // ============================================================
    // Outputs, all from flops
    assign miso_o = miso_q;
    assign miso_oe_o = miso_oe_q;
    assign port_pins_o = data_q;
    assign port_pins_oe_o = dir_q;
    assign compare_flag_o = cmp_flag_q;
    assign drop_o = drop_q;

endmodule // serial_io_port

/* hw/serial_io_port_map.vh */
// Constants for the serially addressed 8-bit I/O port.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SERIAL_IO_PORT_MAP_VH
`define SERIAL_IO_PORT_MAP_VH

// ============================================================
// Control byte field positions
`define CTL_IDENT1_BIT 7
`define CTL_IDENT0_BIT 6
`define CTL_WRITE_BIT 5
`define CTL_DIR_BIT 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 2
`define CTL_CMP_HI 1
`define CTL_CMP_LO 0

// ============================================================
// Write modes for the data byte
`define WMODE_LOAD 2'h0
`define WMODE_SET 2'h1
`define WMODE_CLR 2'h2

// ============================================================
// Compare conditions between data register and pins
`define CMP_EQUAL 2'h0
`define CMP_DIFFER 2'h1
`define CMP_ANY_HIGH 2'h2
`define CMP_NONE_HIGH 2'h3

// ============================================================
// Reset values
`define RST_DATA 8'h00
`define RST_DIR 8'h00
`define RST_CMP_SEL 2'h0
`define RST_SYNC 13'h0800

// ============================================================
// Bit counts within a transfer
`define FLAG_BIT_IDX 3'h2
`define ID_LAST_IDX 3'h1
`define BYTE_LAST_IDX 3'h7

// ============================================================
// Write command buffer shape
`define CMDQ_WIDTH 16
`define CMDQ_DEPTH 16
`define CMDQ_AW 4

`endif

/* hw/cmd_fifo.v */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
module cmd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock_i,             // System clock
    input wire rst_n_i,             // Synchronous reset, active low
    input wire in_valid_i,          // Write request
    output wire in_ready_o,         // Space available
    input wire [WIDTH-1:0] in_data_i, // Write data
    output wire out_valid_o,        // Data available
    input wire out_ready_i,         // Reader takes a word
    output wire [WIDTH-1:0] out_data_o // Head word
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_ptr_q;
    reg [AW:0] rd_ptr_q;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;

    // ============================================================
    // Status from pointer comparison; extra bit tells full from empty
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign do_wr = in_valid_i & ~full;
    assign do_rd = out_ready_i & ~empty;
    assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

    // Storage has no reset; only valid words are ever read
    always @(posedge clock_i) begin
        if (do_wr) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= {(AW+1){1'b0}};
            rd_ptr_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_q <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // cmd_fifo

/* verif/spi_master_model.sv */
// SPI master model for the serial I/O port, clock phase one, either polarity.
// Assumes the bench resolves the serial out wire to z while it is released.
module spi_master_model (
    output logic sck_o,  // Serial clock
    output logic cs_n_o, // Chip enable, active low
    output logic mosi_o, // Serial data to device
    input wire miso_i    // Resolved serial data from device
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle levels at time zero
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // ============================================================
    // Frames
    // msb first, phase one
    task automatic xfer(input logic pol, input logic [15:0] tx, input int n,
                        output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        sck_o = pol;
        #100;
        cs_n_o = 1'b0;
        #100;
        // Leading edge shifts out, trailing edge samples
        for (i = 15; i > 15 - n; i--) begin
            sck_o = ~pol;
            mosi_o = tx[i];
            #62.5;
            sck_o = pol;
            rx[i] = miso_i;
            #62.5;
        end
        #100;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #200;
    endtask
    // Clock and data noise while deselected; even count keeps idle level
    task automatic wiggle();
        int i;
        for (i = 0; i < 8; i++) begin
            sck_o = ~sck_o;
            mosi_o = ~mosi_o;
            #62.5;
        end
    endtask
endmodule // spi_master_model

/* verif/serial_io_port_properties.sv */
// Concurrent checks on the serial I/O port pins.
// Assumes the bind below; one clock, synchronous active-low reset.
module serial_io_port_props (
    input wire clock_i,              // System clock
    input wire rst_n_i,              // Reset, active low
    input wire sck_i,                // Serial clock pin
    input wire cs_n_i,               // Chip enable pin
    input wire miso_o,               // Serial out level
    input wire miso_oe_o,            // Serial out enable
    input wire [7:0] port_pins_i,    // Pin levels
    input wire [7:0] port_pins_o,    // Pin drive levels
    input wire [7:0] port_pins_oe_o, // Pin enables
    input wire compare_flag_o,       // Compare flag
    input wire apply_hold_i,         // Write stall
    input wire drop_o                // Lost write
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [5:0] sck_h;
    logic [5:0] edges_q;
    logic snap_q;
    // ============================================================
    // Helpers: sck history, edges in frame, flag at enable fall
    always @(posedge clock_i) begin
        sck_h <= {sck_h[4:0], sck_i};
        if (cs_n_i)
            edges_q <= 6'h00;
        else if (sck_i != sck_h[0] && edges_q != 6'h3f)
            edges_q <= edges_q + 6'h01;
        if ($fell(cs_n_i))
            snap_q <= compare_flag_o;
    end
    // ============================================================
    // Properties
    property p_rst_vals;
        $rose(rst_n_i) |-> !miso_oe_o && port_pins_oe_o == 8'h00 && port_pins_o == 8'h00;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
    property p_hiz_rise;
        $rose(cs_n_i) |-> ##[1:5] !miso_oe_o;
    endproperty
    a_hiz_rise: assert property (p_hiz_rise) else $error("serial out driven after deselect");
    property p_idle_quiet;
        cs_n_i [*6] |-> !miso_oe_o && $stable(miso_o);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("serial out moved deselected");
    // Enable rises only after the third leading edge of a live frame
    property p_oe_in_frame;
        $rose(miso_oe_o) |-> !cs_n_i && !$past(cs_n_i, 3) && edges_q >= 6'h05;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("enable outside frame");
    property p_miso_sck;
        $changed(miso_o) && miso_oe_o |-> sck_h != 6'h00 && sck_h != 6'h3f;
    endproperty
    a_miso_sck: assert property (p_miso_sck) else $error("serial out moved without sck");
    property p_flag_snap;
        $rose(miso_oe_o) |-> miso_o == snap_q;
    endproperty
    a_flag_snap: assert property (p_flag_snap) else $error("first bit not the flag");
    property p_hold_freeze;
        apply_hold_i [*4] |=> $stable(port_pins_o) && $stable(port_pins_oe_o);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("pins moved while held");
    property p_flag_steady;
        (apply_hold_i && $stable(port_pins_i)) [*6] |=> $stable(compare_flag_o);
    endproperty
    a_flag_steady: assert property (p_flag_steady) else $error("flag moved with no cause");
    // Main scenarios
    c_frame: cover property ($rose(miso_oe_o));
    c_drop: cover property ($rose(drop_o));
    c_held: cover property (apply_hold_i [*8]);
endmodule // serial_io_port_props
bind serial_io_port serial_io_port_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .sck_i(sck_i), .cs_n_i(cs_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .port_pins_i(port_pins_i), .port_pins_o(port_pins_o), .port_pins_oe_o(port_pins_oe_o),
    .compare_flag_o(compare_flag_o), .apply_hold_i(apply_hold_i), .drop_o(drop_o));

/* verif/tb_serial_io_port.sv */
// Self-checking bench for the serial I/O port: random and corner frames.
// Assumes the master model drives the serial pins; bench drives the rest.
module tb_serial_io_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hold = 1'b0;
    logic [1:0] ident = 2'h0;
    logic [7:0] ext = 8'h00;
    logic sck, cs_n, mosi, miso, miso_oe, flag, drop;
    logic [7:0] pins_o, pins_oe, ctl, e_dat, e_dir;
    logic [1:0] e_sel;
    logic [15:0] rx;
    logic [31:0] rnd;
    int n_fail = 0;
    int tests_run = 0;
    int seed = 26234;
    int k;
    // Wire levels: released serial out floats, pins resolve by enable
    wire miso_w = miso_oe ? miso : 1'bz;
    wire [7:0] pins_w = (pins_oe & pins_o) | (~pins_oe & ext);
    always #4 clk = ~clk;
    spi_master_model u_master (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
    serial_io_port u_dut (.clock_i(clk), .rst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .ident_pin_0_i(ident[0]),
        .ident_pin_1_i(ident[1]), .port_pins_i(pins_w), .port_pins_o(pins_o),
        .port_pins_oe_o(pins_oe), .compare_flag_o(flag), .apply_hold_i(hold),
        .drop_o(drop));
    // ============================================================
    // Expectation functions
    function automatic logic f_cmp(input logic [1:0] s, input logic [7:0] d, p);
        case (s)
            2'h0: return d == p;
            2'h1: return d != p;
            2'h2: return (d & p) != 8'h00;
            default: return (d & p) == 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] f_wr(input logic [1:0] m, input logic [7:0] o, v);
        case (m)
            2'h1: return o | v;
            2'h2: return o & ~v;
            default: return v;
        endcase
    endfunction
    function automatic logic [7:0] f_lvl();
        return (e_dir & e_dat) | (~e_dir & ext);
    endfunction
    // ============================================================
    // Compare and closing tasks
    task automatic chk_frame(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One frame, its answer, and the port state once it has landed
    task automatic do_xfer(input logic [7:0] c, d, input logic app);
        logic [15:0] e;
        rnd = $random(seed);
        e = {2'bzz, f_cmp(e_sel, e_dat, f_lvl()), 5'h00, c[4] ? e_dir : f_lvl()};
        if (c[7:6] != ident)
            e = 16'hzzzz;
        u_master.xfer(rnd[0], {c, d}, 16, rx);
        chk_frame("frame", e, rx);
        if (app && c[7:6] == ident && c[5]) begin
            if (c[4])
                e_dir = f_wr(c[3:2], e_dir, d);
            else
                e_dat = f_wr(c[3:2], e_dat, d);
            e_sel = c[1:0];
        end
        @(negedge clk);
        chk_byte("data", e_dat, pins_o);
        chk_byte("dir", e_dir, pins_oe);
        chk_byte("flag", {7'h00, f_cmp(e_sel, e_dat, f_lvl())}, {7'h00, flag});
    endtask
    // Run limit
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
    // ============================================================
    // Main sequence
    initial begin
        e_dat = 8'h00;
        e_dir = 8'h00;
        e_sel = 2'h0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // Every write mode and compare condition first, then random frames
        for (k = 0; k < 40; k++) begin
            rnd = $random(seed);
            ext = rnd[23:16];
            ident = rnd[25:24];
            ctl = rnd[15:8];
            if (k < 16)
                ctl[5:0] = {1'b1, ctl[4], k[3:0]};
            if (k % 5 != 3)
                ctl[7:6] = ident;
            do_xfer(ctl, rnd[7:0], 1'b1);
        end
        // cut-short write, then noise while deselected
        u_master.xfer(1'b0, {ident, 6'h20, ~e_dat}, 10, rx);
        u_master.wiggle();
        do_xfer({ident, 6'h00}, 8'h00, 1'b1);
        // Held queue keeps sixteen writes and loses the seventeenth
        hold = 1'b1;
        for (k = 0; k < 17; k++)
            do_xfer({ident, 6'h20}, k[7:0] + 8'h30, 1'b0);
        chk_byte("drop", 8'h01, {7'h00, drop});
        hold = 1'b0;
        e_dat = 8'h3f;
        e_sel = 2'h0;
        for (k = 0; k < 100 && pins_o !== 8'h3f; k++)
            @(negedge clk);
        // A drain that never lands counts as a mismatch and goes to the verdict
        if (pins_o !== 8'h3f) begin
            n_fail++;
        end else begin
            @(negedge clk);
            do_xfer({ident, 6'h00}, 8'h00, 1'b1);
            chk_byte("drop", 8'h00, {7'h00, drop});
        end
        close_out();
    end
endmodule // tb_serial_io_port
